// [tcm_defs.svh]
// Operation
// - A management input turns off trace mismatch detection.
// - Degrade defect comes from per-second near errored block counts against threshold settings.
// - Remote defect follows the received remote defect bit after persistence filtering.
// - Outgoing defect follows the received outgoing defect bit, same filtering.
// - Trail fail is server fail, unequipped, mismatch or loss; trail degrade is degrade.
// - Unequipped cause when monitored; loss cause only without unequipped.
// - Mismatch cause only without unequipped and without loss.
// - Degrade cause only without mismatch and without loss.
// - Remote defect cause, when enabled, only without unequipped, mismatch and loss.
// - Outgoing defect cause, when enabled, only without unequipped, mismatch and loss.
// - Server fail cause when monitored, server fail present and enabled; off after reset.
// - Remote defect reporting enable, disabled after reset.
// - Outgoing defect reporting enable, disabled after reset.
// - Per-second defect seconds and summed near, far and outgoing errored block counts.
// - Mismatch defect is suppressed while server fail is present.
// - Loss of tandem connection equals the out-of-multiframe state.
// - Multiframe alignment on bits 7-8 with pattern FFFE; two bad patterns in a row lose it.
// - Near errored block when parity error count differs from incoming error code, or from zero under the incoming AIS code.
`ifndef TCM_DEFS_SVH
`define TCM_DEFS_SVH
`define TCM_MF_LEN       7'h4C       // frames per multiframe
`define TCM_FAS_PATTERN  16'hFFFE    // alignment signal over frames 1..8
`define TCM_FAS_LAST     7'h07       // index of last alignment frame
`define TCM_RDI_FRAME    7'h48       // index of remote defect frame
`define TCM_ODI_FRAME    7'h49       // index of outgoing defect frame
`define TCM_PERSIST      3'h5        // consecutive samples to change a filtered defect
`define TCM_IAIS_CODE    4'hE        // incoming error code that means incoming AIS
`define TCM_MF_BIT_HI    1           // bit 7 of the overhead byte
`define TCM_MF_BIT_LO    0           // bit 8 of the overhead byte
`define TCM_REI_BIT      3           // bit 5 of the overhead byte
`define TCM_OEI_BIT      2           // bit 6 of the overhead byte
`define TCM_IEC_HI       7
`define TCM_IEC_LO       4
`endif

// [tcm_pkg.sv]
`default_nettype none
package tcm_pkg;
	typedef struct packed {
		logic       mismatch_detect_disable;
		logic       server_fail_report_enable;
		logic       remote_report_enable;
		logic       outgoing_report_enable;
		logic       monitored_state;
		logic [3:0] deg_seconds;   // consecutive bad seconds to set degrade
		logic [13:0] deg_threshold; // errored blocks that make a bad second
	} tcm_cfg_t;
	typedef struct packed {
		logic [7:0] overhead;     // received tandem connection overhead byte
		logic [7:0] parity_diff;  // computed parity xor received parity bits
	} tcm_frame_t;
	typedef struct packed {
		logic unequipped_cause;
		logic tc_loss_cause;
		logic mismatch_cause;
		logic degrade_cause;
		logic server_fail_cause;
		logic remote_defect_cause;
		logic outgoing_defect_cause;
	} tcm_cause_t;
	typedef struct packed {
		logic        near_defect_second;
		logic        far_defect_second;
		logic        outgoing_defect_second;
		logic [13:0] near_block_error_count;
		logic [13:0] far_block_error_count;
		logic [13:0] outgoing_block_error_count;
	} tcm_perf_t;
	typedef enum logic {TCM_OOM, TCM_IM} tcm_mf_state_t;
endpackage : tcm_pkg
`default_nettype wire

// [tcm_sink.sv]
`include "tcm_defs.svh"
`default_nettype none
module tcm_sink #(
	parameter int CNT_W = 14
) (
	input  wire logic               sys_clk_i,
	input  wire logic               nrst_i,
	input  wire logic               frame_strobe_i,
	input  wire tcm_pkg::tcm_frame_t frame_i,
	input  wire logic               server_fail_in_i,
	input  wire logic               trace_mismatch_i,
	input  wire logic               equipment_defect_i,
	input  wire logic               one_second_i,
	input  wire tcm_pkg::tcm_cfg_t  cfg_i,
	output var  logic               trail_fail_out_o,
	output var  logic               trail_degrade_out_o,
	output var  tcm_pkg::tcm_cause_t cause_o,
	output var  tcm_pkg::tcm_perf_t  perf_o,
	output var  logic               out_of_multiframe_state_o
);
	import tcm_pkg::*;

	// refuse any counter width other than the 14 bits of the performance outputs
	generate
		if (CNT_W != 14) begin : g_bad_cnt_w
			$error("CNT_W must match the performance record width");
		end
	endgenerate

	// number of ones in a byte
	function automatic logic [3:0] ones8(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++)
			n = n + {3'b000, v[i]};
		return n;
	endfunction

	tcm_cfg_t      cfg;
	tcm_mf_state_t mf_state;
	logic [15:0]   fas_sr;
	logic [15:0]   next_fas;
	logic [6:0]    mf_pos;
	logic          fas_err;
	logic          unequipped_defect;
	logic          trace_mismatch_defect;
	logic          degrade_defect;
	logic          remote_defect;
	logic          outgoing_defect;
	logic          tc_loss_defect;
	logic          near_errored_block;
	logic          far_errored_block;
	logic          outgoing_errored_block;
	logic [3:0]    iec;
	logic [3:0]    perr;
	logic          trail_fail;

	// management settings held with reporting disabled out of reset
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg <= '0;
		end else begin
			cfg <= cfg_i;
		end
	end

	// overhead decode of the current frame
	assign next_fas = {fas_sr[13:0], frame_i.overhead[`TCM_MF_BIT_HI],
		frame_i.overhead[`TCM_MF_BIT_LO]};
	assign iec  = frame_i.overhead[`TCM_IEC_HI:`TCM_IEC_LO];
	assign perr = ones8(frame_i.parity_diff);

	// near end errored block on any difference; incoming AIS code counts as zero
	always_comb begin
		if (iec == `TCM_IAIS_CODE)
			near_errored_block = (perr != 4'h0);
		else
			near_errored_block = (perr != iec);
	end
	assign far_errored_block      = frame_i.overhead[`TCM_REI_BIT];
	assign outgoing_errored_block = frame_i.overhead[`TCM_OEI_BIT];

	// alignment history of bits 7 and 8
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fas_sr <= 16'h0000;
		end else if (frame_strobe_i) begin
			fas_sr <= next_fas;
		end
	end

	// multiframe alignment: search when out, check each multiframe when in
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mf_state <= TCM_OOM;
			mf_pos   <= 7'h00;
			fas_err  <= 1'b0;
		end else if (frame_strobe_i) begin
			case (mf_state)
				TCM_OOM: begin
					if (next_fas == `TCM_FAS_PATTERN) begin
						mf_state <= TCM_IM;
						mf_pos   <= `TCM_FAS_LAST + 7'h01;
						fas_err  <= 1'b0;
					end
				end
				TCM_IM: begin
					if (mf_pos == `TCM_MF_LEN - 7'h01)
						mf_pos <= 7'h00;
					else
						mf_pos <= mf_pos + 7'h01;
					if (mf_pos == `TCM_FAS_LAST) begin
						if (next_fas == `TCM_FAS_PATTERN) begin
							fas_err <= 1'b0;
						end else if (fas_err) begin
							mf_state <= TCM_OOM;
							fas_err  <= 1'b0;
						end else begin
							fas_err <= 1'b1;
						end
					end
				end
				default: begin
					mf_state <= TCM_OOM;
				end
			endcase
		end
	end

	// loss of tandem connection follows the alignment state
	assign tc_loss_defect = (mf_state == TCM_OOM);

	// persistence filters: 0 unequipped, 1 remote defect, 2 outgoing defect
	logic [2:0] flt_strobe;
	logic [2:0] flt_value;
	logic [2:0] flt_state;
	assign flt_strobe[0] = frame_strobe_i;
	assign flt_value[0]  = (frame_i.overhead == 8'h00);
	assign flt_strobe[1] = frame_strobe_i && (mf_state == TCM_IM)
		&& (mf_pos == `TCM_RDI_FRAME);
	assign flt_value[1]  = frame_i.overhead[`TCM_MF_BIT_LO];
	assign flt_strobe[2] = frame_strobe_i && (mf_state == TCM_IM)
		&& (mf_pos == `TCM_ODI_FRAME);
	assign flt_value[2]  = frame_i.overhead[`TCM_MF_BIT_HI];

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_flt
			logic [2:0] run;
			// a defect changes after consecutive samples that disagree with it
			always_ff @(posedge sys_clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					run          <= 3'h0;
					flt_state[g] <= 1'b0;
				end else if (flt_strobe[g]) begin
					if (flt_value[g] == flt_state[g]) begin
						run <= 3'h0;
					end else if (run == `TCM_PERSIST - 3'h1) begin
						run          <= 3'h0;
						flt_state[g] <= flt_value[g];
					end else begin
						run <= run + 3'h1;
					end
				end
			end
		end
	endgenerate
	assign unequipped_defect = flt_state[0];
	assign remote_defect     = flt_state[1];
	assign outgoing_defect   = flt_state[2];

	// trace mismatch, switchable and held off under server fail
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			trace_mismatch_defect <= 1'b0;
		end else begin
			trace_mismatch_defect <= trace_mismatch_i
				&& !cfg.mismatch_detect_disable
				&& !server_fail_in_i;
		end
	end

	// degrade: per-second near errored block count versus threshold
	logic [CNT_W-1:0] deg_blocks;
	logic [3:0]       bad_run;
	logic [3:0]       good_run;
	logic             bad_second;
	assign bad_second = (deg_blocks >= cfg.deg_threshold);
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			deg_blocks     <= '0;
			bad_run        <= 4'h0;
			good_run       <= 4'h0;
			degrade_defect <= 1'b0;
		end else if (one_second_i) begin
			deg_blocks <= CNT_W'(frame_strobe_i && near_errored_block);
			if (bad_second) begin
				good_run <= 4'h0;
				if (bad_run + 4'h1 >= cfg.deg_seconds)
					degrade_defect <= 1'b1;
				else
					bad_run <= bad_run + 4'h1;
			end else begin
				bad_run <= 4'h0;
				if (good_run + 4'h1 >= cfg.deg_seconds)
					degrade_defect <= 1'b0;
				else
					good_run <= good_run + 4'h1;
			end
			if (bad_second == degrade_defect) begin
				bad_run  <= 4'h0;
				good_run <= 4'h0;
			end
		end else if (frame_strobe_i && near_errored_block
			&& deg_blocks != '1) begin
			deg_blocks <= deg_blocks + CNT_W'(1);
		end
	end

	// consequent actions and fault cause correlation
	assign trail_fail = server_fail_in_i || unequipped_defect
		|| trace_mismatch_defect || tc_loss_defect;
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			trail_fail_out_o          <= 1'b1;
			trail_degrade_out_o       <= 1'b0;
			cause_o                   <= '0;
			out_of_multiframe_state_o <= 1'b1;
		end else begin
			trail_fail_out_o          <= trail_fail;
			trail_degrade_out_o       <= degrade_defect;
			out_of_multiframe_state_o <= tc_loss_defect;
			cause_o.unequipped_cause <= cfg.monitored_state
				&& unequipped_defect;
			cause_o.tc_loss_cause <= cfg.monitored_state
				&& !unequipped_defect && tc_loss_defect;
			cause_o.mismatch_cause <= cfg.monitored_state
				&& !unequipped_defect && !tc_loss_defect
				&& trace_mismatch_defect;
			cause_o.degrade_cause <= cfg.monitored_state
				&& !trace_mismatch_defect && !tc_loss_defect
				&& degrade_defect;
			cause_o.server_fail_cause <= cfg.monitored_state
				&& server_fail_in_i
				&& cfg.server_fail_report_enable;
			cause_o.remote_defect_cause <= cfg.monitored_state
				&& !unequipped_defect && !trace_mismatch_defect
				&& !tc_loss_defect && remote_defect
				&& cfg.remote_report_enable;
			cause_o.outgoing_defect_cause <= cfg.monitored_state
				&& !unequipped_defect && !trace_mismatch_defect
				&& !tc_loss_defect && outgoing_defect
				&& cfg.outgoing_report_enable;
		end
	end

	// one-second accumulation; an event in the tick cycle opens the next second
	logic             acc_nds;
	logic             acc_fds;
	logic             acc_ods;
	logic [CNT_W-1:0] acc_nebc;
	logic [CNT_W-1:0] acc_febc;
	logic [CNT_W-1:0] acc_oebc;
	logic             inc_n;
	logic             inc_f;
	logic             inc_o;
	assign inc_n = frame_strobe_i && near_errored_block;
	assign inc_f = frame_strobe_i && far_errored_block;
	assign inc_o = frame_strobe_i && outgoing_errored_block;
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			acc_nds  <= 1'b0;
			acc_fds  <= 1'b0;
			acc_ods  <= 1'b0;
			acc_nebc <= '0;
			acc_febc <= '0;
			acc_oebc <= '0;
		end else if (one_second_i) begin
			acc_nds  <= trail_fail || equipment_defect_i;
			acc_fds  <= remote_defect;
			acc_ods  <= outgoing_defect;
			acc_nebc <= CNT_W'(inc_n);
			acc_febc <= CNT_W'(inc_f);
			acc_oebc <= CNT_W'(inc_o);
		end else begin
			acc_nds  <= acc_nds || trail_fail || equipment_defect_i;
			acc_fds  <= acc_fds || remote_defect;
			acc_ods  <= acc_ods || outgoing_defect;
			if (inc_n && acc_nebc != '1)
				acc_nebc <= acc_nebc + CNT_W'(1);
			if (inc_f && acc_febc != '1)
				acc_febc <= acc_febc + CNT_W'(1);
			if (inc_o && acc_oebc != '1)
				acc_oebc <= acc_oebc + CNT_W'(1);
		end
	end

	// results of the finished second, held until the next tick
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			perf_o <= '0;
		end else if (one_second_i) begin
			perf_o.near_defect_second         <= acc_nds;
			perf_o.far_defect_second          <= acc_fds;
			perf_o.outgoing_defect_second     <= acc_ods;
			perf_o.near_block_error_count     <= acc_nebc;
			perf_o.far_block_error_count      <= acc_febc;
			perf_o.outgoing_block_error_count <= acc_oebc;
		end
	end

endmodule // tcm_sink
`default_nettype wire

// [tcm_src_model.sv]
`default_nettype none
module tcm_src_model (
	input  wire logic                clk_i,
	input  wire logic                nrst_i,
	input  wire logic                fas_bad_i,
	input  wire logic                rdi_i,
	input  wire logic                odi_i,
	input  wire logic                errs_i,
	input  wire logic                iais_i,
	input  wire logic                uneq_i,
	output var  logic                strobe_o,
	output var  tcm_pkg::tcm_frame_t frame_o
);
	import tcm_pkg::*;
	logic [6:0] idx;
	logic [1:0] mf_bits;
	// one frame per cycle after reset, index wraps after 76 frames
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			strobe_o <= 1'b0;
			idx      <= 7'h00;
		end else begin
			strobe_o <= 1'b1;
			if (strobe_o) begin
				idx <= (idx == 7'h4B) ? 7'h00 : idx + 7'h01;
			end
		end
	end
	// alignment word ends 10 on frame 7, flags ride in frames 72 and 73
	always_comb begin
		mf_bits = 2'b00;
		if (idx < 7'h08) begin
			mf_bits = fas_bad_i ? 2'b00 : ((idx == 7'h07) ? 2'b10 : 2'b11);
		end
		if (idx == 7'h48) begin
			mf_bits = {1'b0, rdi_i};
		end
		if (idx == 7'h49) begin
			mf_bits = {odi_i, 1'b0};
		end
	end
	// code 1 against one parity difference is clean, errs adds a second difference;
	// incoming AIS code with no difference is clean, unequipped sends an all-zero frame
	assign frame_o = uneq_i ? 16'h0000
		: {(iais_i ? 4'hE : 4'h1), errs_i, errs_i, mf_bits, 6'h00, errs_i, ~iais_i};
endmodule // tcm_src_model
`default_nettype wire

// [tcm_sink_monitor.sv]
`default_nettype none
module tcm_sink_monitor #(
	parameter int CNT_W = 14
) (
	input wire logic                sys_clk_i,
	input wire logic                nrst_i,
	input wire logic                server_fail_in_i,
	input wire logic                one_second_i,
	input wire tcm_pkg::tcm_cfg_t   cfg_i,
	input wire logic                trail_fail_out_o,
	input wire logic                trail_degrade_out_o,
	input wire tcm_pkg::tcm_cause_t cause_o,
	input wire tcm_pkg::tcm_perf_t  perf_o,
	input wire logic                out_of_multiframe_state_o
);
	import tcm_pkg::*;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	// consequent actions and correlations between registered outputs
	chk_loss_fail: assert property (out_of_multiframe_state_o |-> trail_fail_out_o)
		else $error("loss without trail fail");
	chk_ssf_fail: assert property (server_fail_in_i [*3] |-> trail_fail_out_o)
		else $error("server fail without trail fail");
	chk_deg_signal: assert property (cause_o.degrade_cause |-> trail_degrade_out_o)
		else $error("degrade cause without trail degrade");
	chk_uneq_fail: assert property (cause_o.unequipped_cause |-> trail_fail_out_o)
		else $error("unequipped cause without trail fail");
	chk_loss_cause: assert property (cause_o.tc_loss_cause |->
		out_of_multiframe_state_o && !cause_o.unequipped_cause) else $error("bad loss cause");
	chk_tim_cause: assert property (cause_o.mismatch_cause |->
		!out_of_multiframe_state_o && !cause_o.unequipped_cause) else $error("bad tim cause");
	chk_deg_cause: assert property (cause_o.degrade_cause |->
		!out_of_multiframe_state_o && !cause_o.mismatch_cause) else $error("bad deg cause");
	// a server fail alone may stand beside the remote and outgoing causes
	chk_rdi_cause: assert property (cause_o.remote_defect_cause |->
		!out_of_multiframe_state_o && !cause_o.unequipped_cause && !cause_o.mismatch_cause)
		else $error("remote cause beside a trail defect");
	chk_odi_cause: assert property (cause_o.outgoing_defect_cause |->
		!out_of_multiframe_state_o && !cause_o.unequipped_cause && !cause_o.mismatch_cause)
		else $error("outgoing cause beside a trail defect");
	chk_ssf_cause: assert property (cause_o.server_fail_cause |-> trail_fail_out_o)
		else $error("server cause without trail fail");
	chk_unmon_quiet: assert property ((!cfg_i.monitored_state) [*3] |-> cause_o == '0)
		else $error("cause while unmonitored");
	chk_perf_hold: assert property (!one_second_i |=> $stable(perf_o))
		else $error("counts moved without tick");
endmodule // tcm_sink_monitor
bind tcm_sink tcm_sink_monitor #(.CNT_W(CNT_W)) u_mon (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
	.server_fail_in_i(server_fail_in_i), .one_second_i(one_second_i), .cfg_i(cfg_i),
	.trail_fail_out_o(trail_fail_out_o), .trail_degrade_out_o(trail_degrade_out_o),
	.cause_o(cause_o), .perf_o(perf_o), .out_of_multiframe_state_o(out_of_multiframe_state_o));
`default_nettype wire

// [tcm_tb.sv]
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import tcm_pkg::*;
	logic sys_clk = 0, nrst = 0, ssf = 0, tmm = 0, eq = 0, tick = 0;
	logic fas_bad = 0, rdi = 0, odi = 0, errs = 0, strobe, fail, deg, out_of_multiframe_state;
	logic iais = 0, uneq = 0;
	tcm_frame_t frame;
	tcm_cfg_t   cfg = '0;
	tcm_cause_t cause;
	tcm_perf_t  perf;
	int err_count = 0;
	int num_checks = 0;
	tcm_src_model u_src (.clk_i(sys_clk), .nrst_i(nrst), .fas_bad_i(fas_bad), .rdi_i(rdi),
		.odi_i(odi), .errs_i(errs), .iais_i(iais), .uneq_i(uneq), .strobe_o(strobe),
		.frame_o(frame));
	tcm_sink u_dut (.sys_clk_i(sys_clk), .nrst_i(nrst), .frame_strobe_i(strobe),
		.frame_i(frame), .server_fail_in_i(ssf), .trace_mismatch_i(tmm),
		.equipment_defect_i(eq), .one_second_i(tick), .cfg_i(cfg), .trail_fail_out_o(fail),
		.trail_degrade_out_o(deg), .cause_o(cause), .perf_o(perf),
		.out_of_multiframe_state_o(out_of_multiframe_state));
	// 40 MHz clock
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic pulse_tick;
		@(posedge sys_clk);
		tick <= 1'b1;
		@(posedge sys_clk);
		tick <= 1'b0;
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// alignment found, lost after bad words, found again
	task automatic t_align;
		cyc(90);
		check("aligned oom", 0, out_of_multiframe_state);
		check("aligned fail", 0, fail);
		@(posedge sys_clk);
		fas_bad <= 1'b1;
		cyc(240);
		check("lost oom", 1, out_of_multiframe_state);
		check("loss cause", 1, cause.tc_loss_cause);
		@(posedge sys_clk);
		fas_bad <= 1'b0;
		cyc(90);
		check("realign", 0, out_of_multiframe_state);
		$display("test align done");
	endtask
	// six errored frames plus an equipment defect, then clean frames with the AIS code
	task automatic t_second;
		pulse_tick;
		errs <= 1'b1;
		eq   <= 1'b1;
		@(posedge sys_clk);
		eq <= 1'b0;
		repeat (5) @(posedge sys_clk);
		errs <= 1'b0;
		iais <= 1'b1;
		repeat (4) @(posedge sys_clk);
		iais <= 1'b0;
		pulse_tick;
		cyc(2);
		check("near count", 6, perf.near_block_error_count);
		check("far count", 6, perf.far_block_error_count);
		check("out count", 6, perf.outgoing_block_error_count);
		check("near second", 1, perf.near_defect_second);
		check("far second", 0, perf.far_defect_second);
		check("degrade out", 1, deg);
		check("degrade cause", 1, cause.degrade_cause);
		pulse_tick;
		cyc(2);
		check("degrade clear", 0, deg);
		check("quiet second", 0, perf.near_defect_second);
		$display("test second done");
	endtask
	// mismatch against server fail, its disable and the monitored state
	task automatic t_fail;
		@(posedge sys_clk);
		tmm <= 1'b1;
		cyc(4);
		check("tim cause", 1, cause.mismatch_cause);
		check("tim fail", 1, fail);
		@(posedge sys_clk);
		ssf <= 1'b1;
		cyc(4);
		check("tim under ssf", 0, cause.mismatch_cause);
		check("ssf unreported", 0, cause.server_fail_cause);
		@(posedge sys_clk);
		cfg.server_fail_report_enable <= 1'b1;
		cyc(4);
		check("ssf cause", 1, cause.server_fail_cause);
		@(posedge sys_clk);
		cfg.monitored_state <= 1'b0;
		cyc(4);
		check("unmonitored", 0, cause);
		@(posedge sys_clk);
		cfg.monitored_state         <= 1'b1;
		cfg.mismatch_detect_disable <= 1'b1;
		ssf                         <= 1'b0;
		cyc(4);
		check("tim disabled", 0, cause.mismatch_cause);
		check("fail clear", 0, fail);
		@(posedge sys_clk);
		cfg.mismatch_detect_disable <= 1'b0;
		tmm                         <= 1'b0;
		$display("test fail done");
	endtask
	// remote and outgoing flags with reporting off, then on
	task automatic t_remote;
		@(posedge sys_clk);
		rdi <= 1'b1;
		odi <= 1'b1;
		cyc(532);
		check("rdi default", 0, cause.remote_defect_cause);
		check("odi default", 0, cause.outgoing_defect_cause);
		@(posedge sys_clk);
		cfg.remote_report_enable   <= 1'b1;
		cfg.outgoing_report_enable <= 1'b1;
		cyc(4);
		check("rdi cause", 1, cause.remote_defect_cause);
		check("odi cause", 1, cause.outgoing_defect_cause);
		pulse_tick;
		pulse_tick;
		cyc(1);
		check("far second", 1, perf.far_defect_second);
		check("out second", 1, perf.outgoing_defect_second);
		@(posedge sys_clk);
		rdi <= 1'b0;
		odi <= 1'b0;
		cyc(532);
		check("rdi cleared", 0, cause.remote_defect_cause);
		check("odi cleared", 0, cause.outgoing_defect_cause);
		$display("test remote done");
	endtask
	// all-zero overhead: unequipped hides the loss cause it brings about
	task automatic t_uneq;
		@(posedge sys_clk);
		uneq <= 1'b1;
		cyc(240);
		check("uneq cause", 1, cause.unequipped_cause);
		check("uneq hides loss", 0, cause.tc_loss_cause);
		check("uneq oom", 1, out_of_multiframe_state);
		check("uneq fail", 1, fail);
		@(posedge sys_clk);
		uneq <= 1'b0;
		cyc(90);
		check("uneq clear", 0, cause.unequipped_cause);
		check("uneq realign", 0, out_of_multiframe_state);
		$display("test unequipped done");
	endtask
	// watchdog cuts a hang short
	initial begin
		repeat (6000) @(posedge sys_clk);
		err_count++;
		summarize;
	end
	// main sequence
	initial begin
		cyc(16);
		check("reset fail", 1, fail);
		check("reset oom", 1, out_of_multiframe_state);
		check("reset cause", 0, cause);
		check("reset perf", 0, |perf);
		@(posedge sys_clk);
		nrst                <= 1'b1;
		cfg.monitored_state <= 1'b1;
		cfg.deg_seconds     <= 4'h1;
		cfg.deg_threshold   <= 14'h0005;
		t_align;
		t_second;
		t_fail;
		t_remote;
		t_uneq;
		summarize;
	end
endmodule // testbench
`default_nettype wire
